// ### rtl/bsr_map.svh
// constants for the bus stall and release control block
// assumes inclusion by bare name from the design file
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH
`define BSR_ADDR_W 24
`define BSR_MUX_W 16
`define BSR_PORT_W 8
`define BSR_ST_REFRESH 2'h0
`define BSR_ST_RELEASED 2'h1
`define BSR_ST_DMA 2'h2
`define BSR_ST_CPU 2'h3
`endif

// ### rtl/bsr_pkg.sv
// types for the bus stall and release control block
// assumes nothing of its surroundings
package bsr_pkg;
    typedef enum logic [2:0]
    {
        BSR_RUN = 3'b000,
        BSR_STALL = 3'b001,
        BSR_REL_STATUS = 3'b010,
        BSR_RELEASED = 3'b011,
        BSR_REL_END = 3'b100,
        BSR_REFRESH = 3'b101
    } bsr_state_t;
endpackage

// ### rtl/bsr_ctrl.sv
// stall and bus-release control between the core bus unit and the pins
// assumes the bus clock output toggles on the core clock; request pins are asynchronous
`timescale 1ns/1ps
`include "bsr_map.svh"

module bsr_ctrl
(
    input wire logic clock, // 200 mhz core clock
    input wire logic rst, // async reset, active high
    input wire logic bus_clk_out, // bus clock output level, core domain
    input wire logic stall_req_n, // stall request pin
    input wire logic release_req_n, // bus release request pin
    input wire logic stop_instruction, // stop instruction halts internal clock
    input wire logic sleep_instruction, // sleep instruction halts internal clock
    input wire logic refresh_bus_request, // memory refresh wants the bus
    input wire logic refresh_active, // refresh owns the bus this cycle
    input wire logic dma_active, // dma owns the bus
    input wire logic req_sample, // bus request sampling window
    input wire logic access_busy, // access or second half of 16-bit pair running
    input wire logic bus_idle, // no bus cycle this period
    input wire logic [`BSR_ADDR_W-1:0] core_addr, // address from bus unit
    input wire logic [`BSR_MUX_W-1:0] core_mux_o, // mux bus out value
    input wire logic core_mux_oe, // mux bus drive
    input wire logic core_strobe_n, // access strobe
    input wire logic core_write_n, // write select
    input wire logic core_ble_n, // lower byte select
    input wire logic core_bhe_n, // upper byte select
    input wire logic core_ale, // address latch strobe
    input wire logic [`BSR_PORT_W-1:0] core_port_o, // port outputs
    output logic cpu_clk_en, // cpu clock enable
    output logic int_clk_en, // internal clock enable
    output logic watchdog_en, // watchdog run enable
    output logic [`BSR_ADDR_W-1:0] addr_o, // address pins
    output logic addr_oe, // address pins drive
    output logic [`BSR_MUX_W-1:0] mux_o, // mux address/data pins
    output logic mux_oe, // mux pins drive
    output logic strobe_n, // access strobe pin
    output logic write_n, // write select pin
    output logic write_oe, // write select drive
    output logic lower_byte_select_n, // lower byte select pin
    output logic upper_byte_select_n, // upper byte select pin
    output logic byte_sel_oe, // byte selects drive
    output logic ale_o, // address latch strobe pin
    output logic bus_owner_status_hi, // status upper bit
    output logic bus_owner_status_lo, // status lower bit
    output logic [`BSR_PORT_W-1:0] port_o // port output pins
);

    // =========================================================
    // input synchronisers
    logic [2:0] stall_sync_r;
    logic [2:0] rel_sync_r;
    logic stall_lvl_r;
    logic rel_lvl_r;
    logic bclk_d_r;
    logic [2:0] bclk_sync_r;
    logic bclk_lvl_r;
    logic bclk_fall;
    logic bclk_rise;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stall_sync_r <= 3'h7;
            rel_sync_r <= 3'h7;
            stall_lvl_r <= 1'b1;
            rel_lvl_r <= 1'b1;
        end
        else
        begin
            stall_sync_r <= {stall_sync_r[1:0], stall_req_n};
            rel_sync_r <= {rel_sync_r[1:0], release_req_n};
            // a change counts once the two later stages agree
            if (stall_sync_r[2] == stall_sync_r[1])
                stall_lvl_r <= stall_sync_r[2];
            if (rel_sync_r[2] == rel_sync_r[1])
                rel_lvl_r <= rel_sync_r[2];
        end
    end

    // the bus clock is sampled like any pin; edges come from the filtered level only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bclk_sync_r <= 3'h0;
            bclk_lvl_r <= 1'b0;
            bclk_d_r <= 1'b0;
        end
        else
        begin
            bclk_sync_r <= {bclk_sync_r[1:0], bus_clk_out};
            if (bclk_sync_r[2] == bclk_sync_r[1])
                bclk_lvl_r <= bclk_sync_r[2];
            bclk_d_r <= bclk_lvl_r;
        end
    end

    assign bclk_fall = bclk_d_r & ~bclk_lvl_r;
    assign bclk_rise = ~bclk_d_r & bclk_lvl_r;

    // =========================================================
    // request sampling
    bsr_pkg::bsr_state_t state_r;
    bsr_pkg::bsr_state_t state_nxt;
    logic stall_seen_r;
    logic rel_req_r;
    logic halted;

    assign halted = stop_instruction | sleep_instruction | (state_r == bsr_pkg::BSR_STALL);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            stall_seen_r <= 1'b0;
        else if (bclk_fall)
            stall_seen_r <= ~stall_lvl_r;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rel_req_r <= 1'b0;
        else if (bclk_fall && !halted)
            rel_req_r <= ~rel_lvl_r;
    end

    // =========================================================
    // state machine, advancing on rising bus clock edges
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            bsr_pkg::BSR_RUN:
            begin
                if (stall_seen_r)
                    state_nxt = bsr_pkg::BSR_STALL;
                else if (rel_req_r && req_sample && !refresh_bus_request && !access_busy)
                    state_nxt = bsr_pkg::BSR_REL_STATUS;
            end
            bsr_pkg::BSR_STALL:
            begin
                if (!stall_seen_r)
                    state_nxt = bsr_pkg::BSR_RUN;
            end
            bsr_pkg::BSR_REL_STATUS:
                state_nxt = bsr_pkg::BSR_RELEASED;
            bsr_pkg::BSR_RELEASED:
            begin
                if (refresh_bus_request)
                    state_nxt = bsr_pkg::BSR_REFRESH;
                else if (!rel_req_r)
                    state_nxt = bsr_pkg::BSR_REL_END;
            end
            bsr_pkg::BSR_REFRESH:
            begin
                if (!refresh_bus_request && !refresh_active)
                    state_nxt = bsr_pkg::BSR_RELEASED;
            end
            bsr_pkg::BSR_REL_END:
            begin
                // refresh still outranks the closing cycle of a release
                if (refresh_bus_request)
                    state_nxt = bsr_pkg::BSR_REFRESH;
                else
                    state_nxt = bsr_pkg::BSR_RUN;
            end
            default:
                state_nxt = bsr_pkg::BSR_RUN;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state_r <= bsr_pkg::BSR_RUN;
        else if (bclk_rise)
            state_r <= state_nxt;
    end

    // =========================================================
    // pin drive; frozen copy is captured while running
    logic [`BSR_ADDR_W-1:0] addr_r;
    logic [`BSR_MUX_W-1:0] mux_r;
    logic mux_oe_r;
    logic strobe_r;
    logic write_r;
    logic ble_r;
    logic bhe_r;
    logic ale_r;
    logic [1:0] status_r;
    logic [`BSR_PORT_W-1:0] port_r;
    logic floated;
    logic [1:0] live_status;

    // owner seen by the bus while the cpu holds it
    assign live_status = refresh_active ? `BSR_ST_REFRESH :
                         dma_active ? `BSR_ST_DMA : `BSR_ST_CPU;

    // pins stay let go through the closing cycle so the far master can back off first
    function automatic logic floats_bus(input bsr_pkg::bsr_state_t s);
        return (s == bsr_pkg::BSR_RELEASED) || (s == bsr_pkg::BSR_REFRESH) ||
               (s == bsr_pkg::BSR_REL_END);
    endfunction

    assign floated = floats_bus(state_r);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            addr_r <= '0;
            mux_r <= '0;
            mux_oe_r <= 1'b0;
            strobe_r <= 1'b1;
            write_r <= 1'b1;
            ble_r <= 1'b1;
            bhe_r <= 1'b1;
            ale_r <= 1'b0;
            status_r <= `BSR_ST_CPU;
            port_r <= '0;
        end
        else
        begin
            case (state_r)
                bsr_pkg::BSR_RUN:
                begin
                    // idle periods reissue the previous address
                    if (!bus_idle)
                        addr_r <= core_addr;
                    mux_r <= bus_idle ? mux_r : core_mux_o;
                    mux_oe_r <= core_mux_oe;
                    strobe_r <= core_strobe_n;
                    write_r <= core_write_n;
                    ble_r <= core_ble_n;
                    bhe_r <= core_bhe_n;
                    ale_r <= core_ale;
                    status_r <= live_status;
                    port_r <= core_port_o;
                end
                bsr_pkg::BSR_STALL:
                    ; // everything holds, ports included
                bsr_pkg::BSR_REL_STATUS:
                begin
                    status_r <= `BSR_ST_RELEASED;
                    strobe_r <= 1'b1;
                    ale_r <= 1'b0;
                end
                bsr_pkg::BSR_RELEASED:
                begin
                    strobe_r <= 1'b1;
                    ale_r <= 1'b0;
                    status_r <= `BSR_ST_RELEASED;
                end
                bsr_pkg::BSR_REFRESH:
                    status_r <= `BSR_ST_REFRESH;
                bsr_pkg::BSR_REL_END:
                    status_r <= `BSR_ST_CPU;
                default:
                    status_r <= `BSR_ST_CPU;
            endcase
        end
    end

    assign addr_o = addr_r;
    assign addr_oe = ~floated;
    assign mux_o = mux_r;
    assign mux_oe = mux_oe_r & ~floated;
    assign strobe_n = strobe_r;
    assign write_n = write_r;
    assign write_oe = ~floated;
    assign lower_byte_select_n = ble_r;
    assign upper_byte_select_n = bhe_r;
    assign byte_sel_oe = ~floated;
    assign ale_o = ale_r;
    assign bus_owner_status_hi = status_r[1];
    assign bus_owner_status_lo = status_r[0];
    assign port_o = port_r;

    // =========================================================
    // clock and watchdog enables
    assign cpu_clk_en = (state_r == bsr_pkg::BSR_RUN);
    assign int_clk_en = (state_r != bsr_pkg::BSR_STALL);
    assign watchdog_en = ~floated & (state_r != bsr_pkg::BSR_REL_STATUS);

endmodule

// ### test/bsr_chk.sv
// checker for the stall and release control pins of bsr_ctrl
// assumes it is bound onto bsr_ctrl and sees its ports only
`timescale 1ns/1ps
`include "bsr_map.svh"
module bsr_chk
(
    input wire logic clock, // core clock
    input wire logic rst, // async reset
    input wire logic stall_req_n, // stall pin
    input wire logic release_req_n, // release pin
    input wire logic refresh_bus_request, // refresh pending
    input wire logic access_busy, // access running
    input wire logic cpu_clk_en, // cpu clock
    input wire logic int_clk_en, // internal clock
    input wire logic watchdog_en, // watchdog
    input wire logic [`BSR_ADDR_W-1:0] addr_o, // address pins
    input wire logic addr_oe, // address drive
    input wire logic strobe_n, // strobe pin
    input wire logic ale_o, // latch strobe
    input wire logic bus_owner_status_hi, // status hi
    input wire logic bus_owner_status_lo, // status lo
    input wire logic [`BSR_PORT_W-1:0] port_o // port pins
);
    wire logic [1:0] st = {bus_owner_status_hi, bus_owner_status_lo};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ======================================================
    // stall
    stall_enter_a: assert property ($fell(stall_req_n) ##1 !stall_req_n [*8] |-> ##[0:60] !int_clk_en)
        else $error("stall not entered");
    stall_exit_a: assert property ($rose(stall_req_n) ##1 stall_req_n [*8] |-> ##[0:60] int_clk_en)
        else $error("stall not left");
    stall_clock_a: assert property (!int_clk_en |-> !cpu_clk_en)
        else $error("cpu clock runs while stalled");
    pins_frozen_a: assert property ($past(!int_clk_en) && !int_clk_en |-> $stable(addr_o) && $stable(port_o))
        else $error("pins moved while stalled");
    // ======================================================
    // release
    float_pins_a: assert property (!addr_oe |-> strobe_n && !ale_o && !cpu_clk_en && !watchdog_en)
        else $error("released pin levels wrong");
    status_first_a: assert property ($fell(addr_oe) |-> $past(st) == `BSR_ST_RELEASED)
        else $error("bus floated before status change");
    grant_gate_a: assert property ($fell(cpu_clk_en) && int_clk_en |-> !$past(refresh_bus_request) && !$past(access_busy))
        else $error("grant while refresh or access pending");
    release_end_a: assert property ($rose(release_req_n) && !addr_oe |-> ##[1:80] addr_oe && st == `BSR_ST_CPU)
        else $error("release not ended");
    refresh_first_a: assert property (refresh_bus_request && !addr_oe |-> ##[0:60] st == `BSR_ST_REFRESH)
        else $error("refresh held off by release");
endmodule
bind bsr_ctrl bsr_chk u_chk
(
    .clock(clock),
    .rst(rst),
    .stall_req_n(stall_req_n),
    .release_req_n(release_req_n),
    .refresh_bus_request(refresh_bus_request),
    .access_busy(access_busy),
    .cpu_clk_en(cpu_clk_en),
    .int_clk_en(int_clk_en),
    .watchdog_en(watchdog_en),
    .addr_o(addr_o),
    .addr_oe(addr_oe),
    .strobe_n(strobe_n),
    .ale_o(ale_o),
    .bus_owner_status_hi(bus_owner_status_hi),
    .bus_owner_status_lo(bus_owner_status_lo),
    .port_o(port_o)
);

// ### test/bsr_far.sv
// far-side logic driving the stall and release request pins
// assumes the bench sets want_stall and want_rel off the clock edge
`timescale 1ns/1ps
module bsr_far
(
    input wire logic clock, // core clock
    input wire logic want_stall, // bench asks for a stall
    input wire logic want_rel, // bench asks for the bus
    input wire logic addr_oe, // device drives the address pins
    output logic stall_req_n = 1'b1, // stall request pin
    output logic release_req_n = 1'b1, // release request pin
    output logic ext_drive = 1'b0 // far master drives the bus
);
    always @(posedge clock)
        stall_req_n <= !want_stall;
    // drive only once floated; let go of the bus before raising the request
    always @(posedge clock)
    begin
        ext_drive <= want_rel && !addr_oe;
        release_req_n <= !(want_rel || ext_drive);
    end
endmodule

// ### test/tb_top.sv
// self-checking bench for bsr_ctrl with the far-side request model
// assumes design, checker and far-side files are compiled before it
`timescale 1ns/1ps
`include "bsr_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
`define WT(c) begin n = 0; while (!(c) && n < 300) begin @(posedge clock); n++; end \
    #1; `CHK(n < 300, 1'b1) end
module tb_top;
    logic clock = 1'b0, rst = 1'b1, bus_clk_out = 1'b0, stall_req_n, release_req_n, ext_drive;
    logic stop_instruction = 1'b0, sleep_instruction = 1'b0, refresh_bus_request = 1'b0;
    logic refresh_active = 1'b0, dma_active = 1'b0, req_sample = 1'b1, access_busy = 1'b0;
    logic bus_idle = 1'b0, core_mux_oe = 1'b1, core_strobe_n = 1'b0, core_write_n = 1'b1;
    logic core_ble_n = 1'b0, core_bhe_n = 1'b0, core_ale = 1'b1, want_stall = 1'b0, want_rel = 1'b0;
    logic [`BSR_ADDR_W-1:0] core_addr = 24'h123456, addr_o;
    logic [`BSR_MUX_W-1:0] core_mux_o = 16'ha5c3, mux_o;
    logic [`BSR_PORT_W-1:0] core_port_o = 8'h5a, port_o;
    logic cpu_clk_en, int_clk_en, watchdog_en, addr_oe, mux_oe, strobe_n, write_n, write_oe;
    logic lower_byte_select_n, upper_byte_select_n, byte_sel_oe, ale_o;
    logic bus_owner_status_hi, bus_owner_status_lo;
    int fails = 0, num_checks = 0, n;
    wire logic [1:0] st = {bus_owner_status_hi, bus_owner_status_lo};
    bsr_ctrl dut (.*);
    bsr_far far_end (.clock(clock), .want_stall(want_stall), .want_rel(want_rel),
        .addr_oe(addr_oe), .stall_req_n(stall_req_n), .release_req_n(release_req_n),
        .ext_drive(ext_drive));
    initial forever #2.5 clock = ~clock;
    // bus clock free-running, phase unrelated to the core clock
    initial #1.3 forever #80 bus_clk_out = ~bus_clk_out;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_reset();
        `CHK({st, strobe_n, ale_o, addr_oe, cpu_clk_en}, 6'h3b)
        @(negedge clock);
        rst = 1'b0;
        dma_active = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        `CHK(st, `BSR_ST_DMA)
        @(negedge clock);
        dma_active = 1'b0;
        $display("reset test done");
    endtask
    task automatic t_idle();
        @(negedge clock);
        bus_idle = 1'b1;
        core_addr = 24'h654321;
        core_mux_o = 16'h3c5a;
        core_ble_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHK({addr_o, mux_o, lower_byte_select_n, upper_byte_select_n}, {24'h123456, 16'ha5c3, 2'h2})
        @(negedge clock);
        bus_idle = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK({addr_o, mux_o}, {24'h654321, 16'h3c5a})
        @(negedge clock);
        core_addr = 24'h123456;
        core_mux_o = 16'ha5c3;
        core_ble_n = 1'b0;
        $display("idle test done");
    endtask
    task automatic t_stall();
        @(negedge clock);
        want_stall = 1'b1;
        `WT(!int_clk_en)
        `CHK(cpu_clk_en, 1'b0)
        @(negedge clock);
        core_addr = 24'h0f0f0f;
        core_port_o = 8'hc3;
        core_write_n = 1'b0;
        repeat (100) @(posedge clock);
        #1;
        `CHK({addr_o, port_o, write_n, int_clk_en}, {24'h123456, 8'h5a, 2'h2})
        @(negedge clock);
        want_stall = 1'b0;
        `WT(int_clk_en)
        repeat (3) @(posedge clock);
        #1;
        `CHK({addr_o, cpu_clk_en}, {24'h0f0f0f, 1'b1})
        $display("stall test done");
    endtask
    task automatic t_release();
        @(negedge clock);
        refresh_bus_request = 1'b1;
        want_rel = 1'b1;
        repeat (100) @(posedge clock);
        #1;
        `CHK({cpu_clk_en, addr_oe}, 2'h3)
        @(negedge clock);
        refresh_bus_request = 1'b0;
        access_busy = 1'b1;
        repeat (100) @(posedge clock);
        #1;
        `CHK({cpu_clk_en, addr_oe}, 2'h3)
        @(negedge clock);
        access_busy = 1'b0;
        req_sample = 1'b0;
        repeat (100) @(posedge clock);
        #1;
        `CHK({cpu_clk_en, addr_oe}, 2'h3)
        @(negedge clock);
        req_sample = 1'b1;
        `WT(!cpu_clk_en)
        `CHK({st, watchdog_en, addr_oe}, 4'h5)
        `WT(!addr_oe)
        `CHK({st, strobe_n, ale_o, mux_oe}, 5'h0c)
        `CHK({write_oe, byte_sel_oe, watchdog_en, cpu_clk_en}, 4'h0)
        repeat (4) @(posedge clock);
        #1;
        `CHK(ext_drive, 1'b1)
        @(negedge clock);
        refresh_bus_request = 1'b1;
        refresh_active = 1'b1;
        `WT(st == `BSR_ST_REFRESH)
        `CHK(addr_oe, 1'b0)
        @(negedge clock);
        refresh_bus_request = 1'b0;
        refresh_active = 1'b0;
        `WT(st == `BSR_ST_RELEASED)
        @(negedge clock);
        want_rel = 1'b0;
        `WT(st == `BSR_ST_CPU)
        `CHK({addr_oe, cpu_clk_en}, 2'h0)
        `WT(addr_oe)
        `WT(cpu_clk_en)
        `CHK({st, ext_drive}, 3'h6)
        $display("release test done");
    endtask
    task automatic t_sleep();
        @(negedge clock);
        sleep_instruction = 1'b1;
        want_rel = 1'b1;
        repeat (100) @(posedge clock);
        #1;
        `CHK(addr_oe, 1'b1)
        @(negedge clock);
        sleep_instruction = 1'b0;
        stop_instruction = 1'b1;
        repeat (100) @(posedge clock);
        #1;
        `CHK(addr_oe, 1'b1)
        @(negedge clock);
        stop_instruction = 1'b0;
        `WT(!addr_oe)
        repeat (100) @(posedge clock);
        #1;
        `CHK(addr_oe, 1'b0)
        @(negedge clock);
        want_rel = 1'b0;
        `WT(cpu_clk_en)
        $display("sleep test done");
    endtask
    initial
    begin
        #300000;
        fails++;
        finish_test();
    end
    initial
    begin
        repeat (16) @(posedge clock);
        t_reset();
        t_idle();
        t_stall();
        t_release();
        t_sleep();
        finish_test();
    end
endmodule
